/* File: dmsr_ext_mem.sv */
// external data memory model: latched low address, read and write strobes, wait pin
// assumes one clock, active low strobes, address on ports 0 and 2 while ale pulses
`timescale 1ns/100ps
module dmsr_ext_mem
   import dmsr_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_ale,
   input  wire dmsr_byte_t i_p0,
   input  wire dmsr_byte_t i_p2,
   input  wire logic       i_wr_n,
   input  wire logic       i_rd_n,
   input  wire logic [7:0] i_wait_len,
   output      dmsr_byte_t o_p0,
   output      logic       o_wait
);
   dmsr_byte_t mem [0:65535];
   dmsr_byte_t lat_q  = 8'h00;
   dmsr_byte_t last_q = 8'h00;
   logic [7:0] cnt_q  = 8'h00;

   // contents start as a pattern the bench can recompute
   initial begin
      for (int a = 0; a < 65536; a++) begin
         mem[a] = 8'(a) ^ 8'(a >> 8);
      end
   end

   // low address captured on the latch strobe, data moved under the strobes
   always @(posedge i_clk) begin
      if (i_ale) lat_q <= i_p0;
      if (!i_wr_n) mem[{i_p2, lat_q}] <= i_p0;
      if (!i_rd_n) last_q <= mem[{i_p2, lat_q}];
      cnt_q <= (i_wr_n && i_rd_n) ? 8'h00 : cnt_q + 8'h01;
   end

   // a released bus shows the inverse of the last value, so a stale sample is caught
   assign o_p0 = !i_rd_n ? mem[{i_p2, lat_q}] : ~last_q;
   // wait held for a set number of strobe cycles
   assign o_wait = (!i_wr_n || !i_rd_n) && (cnt_q < i_wait_len);
endmodule : dmsr_ext_mem

/* File: dmsr_params.svh */
// constants for the data memory space router: address map, timing, stretch codes
// assumes inclusion by the package and the modules of this block only
`ifndef DMSR_PARAMS_SVH
`define DMSR_PARAMS_SVH

`define DMSR_SRAM_BYTES     1024
`define DMSR_SRAM_AW        10
`define DMSR_SRAM_LAST      16'h03FF
`define DMSR_CLK_PER_MC     4
`define DMSR_STRETCH_MIN    3'h0
`define DMSR_STRETCH_MAX    3'h7
`define DMSR_EXT_BASE_MC    2
`define DMSR_INT_MC         2
`define DMSR_ENABLE_RST     1'b0

`endif

/* File: dmsr_pkg.sv */
// types for the data memory space router
// assumes dmsr_params.svh is in the include path
`include "dmsr_params.svh"

package dmsr_pkg;

   // bus sequencer states: external bus phases plus the internal sram wait, one-hot
   typedef enum logic [4:0] {
      DMSR_IDLE  = 5'b00001,
      DMSR_ADDR  = 5'b00010,
      DMSR_STRB  = 5'b00100,
      DMSR_WAIT  = 5'b01000,
      DMSR_DONE  = 5'b10000
   } dmsr_state_e;

   typedef logic [15:0] dmsr_addr_t;
   typedef logic [7:0]  dmsr_byte_t;

endpackage : dmsr_pkg

/* File: dmsr_router.sv */
// data memory space router: sends core data moves to the on-chip sram or the external bus
// assumes core request is a one-cycle pulse held stable until o_DONE; one clock domain
`timescale 1ns/100ps
`include "dmsr_params.svh"

// Operation
// (RL1) 1 KB on-chip sram sits at data addresses 0000H to 03FFH, data moves only.
// (RL2) on-chip sram answers only while the sram enable bit is set.
// (RL3) reset clears the sram enable bit, sram starts disabled.
// (RL4) when enabled, addresses above 03FFH go external, the rest internal.
// (RL5) when disabled, every address 0000H to FFFFH goes to the external bus.
// (RL6) external access length adjustable by software from two to nine machine cycles.
// (RL7) a machine cycle is 4 clocks; durations count machine cycles.
// (RL8) port 2 drives high address, port 0 carries low address and data.
// (RL9) port 0 drives both levels while used as address/data bus.
// (RL10) with wait control enabled, port 4 bit 0 is an input extending the access.
// (RL11) external write strobe is driven on port 3 bit 6 during writes.
// (RL12) external read strobe is driven on port 3 bit 7 during reads.
// (RL13) on-chip sram is never a fetch source and is apart from scratchpad.
// (RL14) address latch strobe pulses so low address is captured before data.
// (RL15) internal sram access raises no external strobe and no bus cycle.
// (RL16) internal sram access takes minimum time whatever the stretch setting.
module dmsr_router
   import dmsr_pkg::*;
#(
   parameter int CLK_PER_MC = `DMSR_CLK_PER_MC,
   parameter int EXT_BASE   = `DMSR_EXT_BASE_MC,
   parameter int INT_MC     = `DMSR_INT_MC
) (
   input  wire logic       I_SYS_CLK,
   input  wire logic       I_RST,
   input  wire logic       I_SRAM_EN_WR,
   input  wire logic       I_SRAM_EN_VAL,
   input  wire logic [2:0] I_STRETCH,
   input  wire logic       I_WAIT_EN,
   input  wire logic       I_REQ,
   input  wire logic       I_WE,
   input  wire dmsr_addr_t I_ADDR,
   input  wire dmsr_byte_t I_WDATA,
   input  wire logic       I_P40_WAIT,
   input  wire dmsr_byte_t I_P0,
   output      logic       O_DONE,
   output      dmsr_byte_t O_RDATA,
   output      logic       O_SRAM_EN,
   output      logic       O_BUSY,
   output      dmsr_byte_t O_P0,
   output      logic       O_P0_OE,
   output      dmsr_byte_t O_P2,
   output      logic       O_P2_OE,
   output      logic       O_ALE,
   output      logic       O_WR_N,
   output      logic       O_RD_N
);

   localparam int CW = 6;

   // decide whether an address hits the on-chip sram
   function automatic logic hits_sram(input dmsr_addr_t a, input logic en);
      hits_sram = en && (a <= `DMSR_SRAM_LAST); // see (RL1) see (RL4) see (RL5)
   endfunction : hits_sram

   dmsr_state_e      st_q, st_d;
   logic             en_q, en_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic             done_q, done_d;
   dmsr_byte_t       rdata_q, rdata_d;
   dmsr_byte_t       p0_q, p0_d;
   logic             p0oe_q, p0oe_d;
   dmsr_byte_t       p2_q, p2_d;
   logic             p2oe_q, p2oe_d;
   logic             ale_q, ale_d;
   logic             wrn_q, wrn_d;
   logic             rdn_q, rdn_d;
   logic             we_q, we_d;
   logic             int_q, int_d;
   logic             busy_q, busy_d;
   dmsr_byte_t       sram_rd;
   logic             sram_go;
   logic [CW-1:0]    strb_len;

   // strobe phase length: whole access minus the address machine cycle
   assign strb_len = CW'((EXT_BASE - 1 + int'(I_STRETCH)) * CLK_PER_MC); // see (RL6) see (RL7)

   // sram is only touched by data moves that decode inside; no fetch port exists
   assign sram_go = I_REQ && !busy_q && hits_sram(I_ADDR, en_q); // see (RL13) see (RL2)

   dmsr_sram #(
      .AW (`DMSR_SRAM_AW)
   ) u_sram (
      .i_clk   (I_SYS_CLK),
      .i_en    (sram_go),
      .i_we    (I_WE),
      .i_addr  (I_ADDR[`DMSR_SRAM_AW-1:0]),
      .i_wdata (I_WDATA),
      .o_rdata (sram_rd)
   );

   // next-state for the enable bit and the bus sequencer
   always_comb begin
      st_d    = st_q;
      en_d    = en_q;
      cnt_d   = cnt_q;
      done_d  = 1'b0;
      rdata_d = rdata_q;
      p0_d    = p0_q;
      p0oe_d  = p0oe_q;
      p2_d    = p2_q;
      p2oe_d  = p2oe_q;
      ale_d   = 1'b0;
      wrn_d   = wrn_q;
      rdn_d   = rdn_q;
      we_d    = we_q;
      int_d   = int_q;
      busy_d  = busy_q;
      if (I_SRAM_EN_WR) begin
         en_d = I_SRAM_EN_VAL; // see (RL2)
      end
      case (st_q)
         DMSR_IDLE: begin
            if (I_REQ) begin
               busy_d = 1'b1;
               we_d   = I_WE;
               if (hits_sram(I_ADDR, en_q)) begin
                  // internal path: no ale, no strobes, fixed short time
                  int_d = 1'b1; // see (RL15)
                  cnt_d = CW'(INT_MC * CLK_PER_MC - 1); // see (RL16)
                  st_d  = DMSR_DONE;
               end else begin
                  int_d  = 1'b0;
                  p2_d   = I_ADDR[15:8]; // see (RL8)
                  p2oe_d = 1'b1;
                  p0_d   = I_ADDR[7:0];
                  p0oe_d = 1'b1; // see (RL9)
                  ale_d  = 1'b1; // see (RL14)
                  cnt_d  = CW'(CLK_PER_MC - 1);
                  st_d   = DMSR_ADDR;
               end
            end
         end
         DMSR_ADDR: begin
            // ale high for the first clock only, hold low address one machine cycle then swap to data
            if (cnt_q == '0) begin
               cnt_d = strb_len - CW'(1);
               if (we_q) begin
                  p0_d  = I_WDATA;
                  wrn_d = 1'b0; // see (RL11)
               end else begin
                  p0oe_d = 1'b0;
                  rdn_d  = 1'b0; // see (RL12)
               end
               st_d = DMSR_STRB;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         DMSR_STRB: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - CW'(1);
            end else if (I_WAIT_EN && I_P40_WAIT) begin
               st_d = DMSR_WAIT; // see (RL10)
            end else begin
               rdata_d = we_q ? rdata_q : I_P0;
               wrn_d   = 1'b1;
               rdn_d   = 1'b1;
               p0oe_d  = 1'b0;
               p2oe_d  = 1'b0;
               done_d  = 1'b1;
               busy_d  = 1'b0;
               st_d    = DMSR_IDLE;
            end
         end
         DMSR_WAIT: begin
            // wait pin holds the strobe low, one clock sampling granularity
            if (!(I_WAIT_EN && I_P40_WAIT)) begin
               rdata_d = we_q ? rdata_q : I_P0;
               wrn_d   = 1'b1;
               rdn_d   = 1'b1;
               p0oe_d  = 1'b0;
               p2oe_d  = 1'b0;
               done_d  = 1'b1;
               busy_d  = 1'b0;
               st_d    = DMSR_IDLE;
            end
         end
         DMSR_DONE: begin
            if (cnt_q == '0) begin
               rdata_d = we_q ? rdata_q : sram_rd;
               done_d  = 1'b1;
               busy_d  = 1'b0;
               int_d   = 1'b0;
               st_d    = DMSR_IDLE;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         default: begin
            st_d = DMSR_IDLE;
         end
      endcase
   end

   // registers; enable bit reset clears so the sram starts hidden
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         st_q    <= DMSR_IDLE;
         en_q    <= `DMSR_ENABLE_RST; // see (RL3)
         cnt_q   <= '0;
         done_q  <= 1'b0;
         rdata_q <= 8'h00;
         p0_q    <= 8'h00;
         p0oe_q  <= 1'b0;
         p2_q    <= 8'h00;
         p2oe_q  <= 1'b0;
         ale_q   <= 1'b0;
         wrn_q   <= 1'b1;
         rdn_q   <= 1'b1;
         we_q    <= 1'b0;
         int_q   <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         en_q    <= en_d;
         cnt_q   <= cnt_d;
         done_q  <= done_d;
         rdata_q <= rdata_d;
         p0_q    <= p0_d;
         p0oe_q  <= p0oe_d;
         p2_q    <= p2_d;
         p2oe_q  <= p2oe_d;
         ale_q   <= ale_d;
         wrn_q   <= wrn_d;
         rdn_q   <= rdn_d;
         we_q    <= we_d;
         int_q   <= int_d;
         busy_q  <= busy_d;
      end
   end

   assign O_DONE    = done_q;
   assign O_RDATA   = rdata_q;
   assign O_SRAM_EN = en_q;
   assign O_BUSY    = busy_q;
   assign O_P0      = p0_q;
   assign O_P0_OE   = p0oe_q;
   assign O_P2      = p2_q;
   assign O_P2_OE   = p2oe_q;
   assign O_ALE     = ale_q;
   assign O_WR_N    = wrn_q;
   assign O_RD_N    = rdn_q;

   // assertions
   // length counter restarts in idle, so at done it holds the edges of the whole access
   int unsigned ext_len_q;
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST || st_q == DMSR_IDLE) begin
         ext_len_q <= 0;
      end else begin
         ext_len_q <= ext_len_q + 1;
      end
   end

   a_rst_clears_en: assert property (@(posedge I_SYS_CLK) I_RST |=> !O_SRAM_EN) // see (RL3)
      else $error("sram enable not cleared by reset");
   a_int_no_strobe: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL15)
      int_q |-> (O_WR_N && O_RD_N && !O_P0_OE && !O_ALE))
      else $error("internal access touched the external bus");
   a_int_fixed_time: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL16)
      (st_q == DMSR_IDLE && I_REQ && hits_sram(I_ADDR, en_q)) |-> ##9 O_DONE)
      else $error("internal access not done in fixed time");
   a_disabled_ext: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL5)
      (st_q == DMSR_IDLE && I_REQ && !en_q) |=> O_ALE)
      else $error("disabled sram did not route external");
   a_high_addr_ext: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL4)
      (st_q == DMSR_IDLE && I_REQ && I_ADDR > `DMSR_SRAM_LAST) |=> (O_ALE && O_P2_OE))
      else $error("high address not routed external");
   a_p2_addr: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL8)
      (st_q == DMSR_IDLE && I_REQ && !hits_sram(I_ADDR, en_q)) |=> O_P2 == $past(I_ADDR[15:8]))
      else $error("port 2 lacks high address");
   a_ale_before_strb: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL14)
      $rose(O_ALE) |=> (O_WR_N && O_RD_N)[*3])
      else $error("strobe overlaps address latch phase");
   a_strb_len_min: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL6)
      (O_DONE && !$past(int_q)) |-> (ext_len_q >= EXT_BASE * CLK_PER_MC &&
         (I_WAIT_EN || ext_len_q <= (EXT_BASE + int'(`DMSR_STRETCH_MAX)) * CLK_PER_MC)))
      else $error("external access outside two to nine machine cycles");
   a_addr_mc_len: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL7)
      $rose(O_ALE) |-> ##4 (!O_WR_N || !O_RD_N))
      else $error("address phase not one machine cycle");
   a_wr_strobe: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL11)
      !O_WR_N |-> (O_P0_OE && we_q))
      else $error("write strobe without write data on port 0");
   a_rd_strobe: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL12)
      !O_RD_N |-> (!O_P0_OE && !we_q))
      else $error("read strobe while port 0 driven");
   a_wait_holds: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // see (RL10)
      (st_q == DMSR_WAIT && I_WAIT_EN && I_P40_WAIT) |=> st_q == DMSR_WAIT)
      else $error("wait input did not extend access");

   c_int_access: cover property (@(posedge I_SYS_CLK) int_q ##1 O_DONE);
   c_ext_read:   cover property (@(posedge I_SYS_CLK) $rose(O_RD_N));
   c_ext_write:  cover property (@(posedge I_SYS_CLK) $rose(O_WR_N));
   c_wait_ext:   cover property (@(posedge I_SYS_CLK) st_q == DMSR_WAIT);

endmodule : dmsr_router

/* File: dmsr_sram.sv */
// 1 KB on-chip data sram, one port, synchronous read with one cycle latency
// assumes the caller gates requests; no reset of contents
`timescale 1ns/100ps
`include "dmsr_params.svh"

module dmsr_sram
   import dmsr_pkg::*;
#(
   parameter int AW = `DMSR_SRAM_AW
) (
   input  wire logic          i_clk,
   input  wire logic          i_en,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr,
   input  wire dmsr_byte_t    i_wdata,
   output      dmsr_byte_t    o_rdata
);

   dmsr_byte_t mem [0:(1<<AW)-1];
   dmsr_byte_t rdata_q;

   // array stays out of reset so it can map onto a real ram macro
   always_ff @(posedge i_clk) begin
      if (i_en && i_we) begin
         mem[i_addr] <= i_wdata;
      end
      if (i_en) begin
         rdata_q <= mem[i_addr];
      end
   end

   assign o_rdata = rdata_q;

endmodule : dmsr_sram

/* File: testbench.sv */
// self-checking bench for the data memory space router with an external memory model
// assumes done is seen 8 edges after the request edge inside, 4*(2+stretch) outside
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
   import dmsr_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       en_wr = 1'b0;
   logic       en_val = 1'b0;
   logic       wait_en = 1'b0;
   logic       req = 1'b0;
   logic       we = 1'b0;
   logic [2:0] stretch = 3'h0;
   logic [7:0] wlen = 8'h00;
   dmsr_addr_t addr = 16'h0000;
   dmsr_byte_t wdata = 8'h00;
   dmsr_byte_t rdata, p0_in, p0, p2;
   logic       done, sram_en, busy, p0_oe, p2_oe, ale, wr_n, rd_n, pw;
   int         num_errors = 0;
   int         check_count = 0;

   always #4 clk = ~clk;

   dmsr_router dut (.I_SYS_CLK(clk), .I_RST(rst), .I_SRAM_EN_WR(en_wr), .I_SRAM_EN_VAL(en_val),
      .I_STRETCH(stretch), .I_WAIT_EN(wait_en), .I_REQ(req), .I_WE(we), .I_ADDR(addr),
      .I_WDATA(wdata), .I_P40_WAIT(pw), .I_P0(p0_in), .O_DONE(done), .O_RDATA(rdata),
      .O_SRAM_EN(sram_en), .O_BUSY(busy), .O_P0(p0), .O_P0_OE(p0_oe), .O_P2(p2),
      .O_P2_OE(p2_oe), .O_ALE(ale), .O_WR_N(wr_n), .O_RD_N(rd_n));

   dmsr_ext_mem mem (.i_clk(clk), .i_ale(ale), .i_p0(p0), .i_p2(p2), .i_wr_n(wr_n),
      .i_rd_n(rd_n), .i_wait_len(wlen), .o_p0(p0_in), .o_wait(pw));

   // initial content of the external memory
   function automatic dmsr_byte_t exp_byte(input dmsr_addr_t a);
      return a[7:0] ^ a[15:8];
   endfunction : exp_byte

   // one data move; returns data, edges until done and whether the bus moved
   task automatic access(input logic w, input dmsr_addr_t a, input dmsr_byte_t d,
                         input logic [2:0] s, output dmsr_byte_t q, output int c,
                         output logic x);
      logic bad;
      bad = 1'b0;
      @(posedge clk);
      we <= w;
      addr <= a;
      wdata <= d;
      stretch <= s;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      #1;
      `CHK(busy, 1'b1)
      c = 0;
      x = 1'b0;
      while (done !== 1'b1 && c < 300) begin
         @(posedge clk);
         #1;
         c++;
         if (ale === 1'b1 || wr_n === 1'b0 || rd_n === 1'b0) x = 1'b1;
         if ((!wr_n || !rd_n) && (p2 !== a[15:8] || p2_oe !== 1'b1)) bad = 1'b1;
         if (wr_n === 1'b0 && (p0 !== d || p0_oe !== 1'b1)) bad = 1'b1;
      end
      q = rdata;
      `CHK(busy, 1'b0)
      `CHK(bad, 1'b0)
   endtask : access

   task automatic set_en(input logic v);
      @(posedge clk);
      en_wr <= 1'b1;
      en_val <= v;
      @(posedge clk);
      en_wr <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(sram_en, v)
   endtask : set_en

   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict();
   end

   initial begin
      dmsr_byte_t q, d;
      dmsr_addr_t a;
      int c;
      logic x;
      void'($urandom(32'h299ac227));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(sram_en, 1'b0)
      `CHK({wr_n, rd_n, ale, p0_oe, p2_oe}, 5'b11000)
      // disabled: a low address still goes out on the bus
      a = 16'($urandom_range(16'h03FE));
      d = 8'($urandom);
      access(1'b1, a, d, 3'h0, q, c, x);
      `CHK(x, 1'b1)
      access(1'b0, a, 8'h00, 3'h0, q, c, x);
      `CHK(q, d)
      `CHK(c, 2 * 4)
      // enabled at the longest stretch: corners and a random address stay inside
      set_en(1'b1);
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 16'h0000 : (i == 1) ? 16'h03FF : 16'($urandom_range(16'h03FF));
         d = 8'($urandom);
         access(1'b1, a, d, 3'h7, q, c, x);
         `CHK(x, 1'b0)
         `CHK(c, 2 * 4)
         access(1'b0, a, 8'h00, 3'h7, q, c, x);
         `CHK(q, d)
      end
      // disabled again: the outside byte behind the sram is untouched
      set_en(1'b0);
      access(1'b0, 16'h03FF, 8'h00, 3'h0, q, c, x);
      `CHK(q, exp_byte(16'h03FF))
      // enabled, above the sram: every stretch code on the bus
      set_en(1'b1);
      for (int s = 0; s < 8; s++) begin
         a = (s == 0) ? 16'h0400 : 16'($urandom_range(16'hFFFF, 16'h0800));
         d = 8'($urandom);
         access(1'b1, a, d, 3'(s), q, c, x);
         `CHK(x, 1'b1)
         `CHK(c, (2 + s) * 4)
         access(1'b0, a, 8'h00, 3'(s), q, c, x);
         `CHK(q, d)
         `CHK(c, (2 + s) * 4)
      end
      // wait pin stretches only while the function is on
      @(posedge clk);
      wait_en <= 1'b1;
      wlen <= 8'h0A;
      access(1'b0, 16'h0500, 8'h00, 3'h0, q, c, x);
      `CHK(c > 9 && c <= 20, 1'b1)
      `CHK(q, exp_byte(16'h0500))
      @(posedge clk);
      wait_en <= 1'b0;
      wlen <= 8'h64;
      access(1'b0, 16'h0500, 8'h00, 3'h0, q, c, x);
      `CHK(c, 2 * 4)
      print_verdict();
   end
endmodule : testbench
